// ---- hw/alh_ang_if.sv ----
// angle formatting signals between the controller and its formatter
`timescale 1ns/10ps
`default_nettype none
interface alh_ang_if #(
  parameter int W  = 12,
  parameter int SW = 4
);
  logic [W-1:0]  raw;
  logic [SW-1:0] shift;
  logic          reverse;
  logic [W-1:0]  fmt;

  modport src (output raw, output shift, output reverse, input fmt);
  modport fmtr (input raw, input shift, input reverse, output fmt);
endinterface : alh_ang_if
`default_nettype wire

// ---- hw/alh_angle_fmt.sv ----
// pole-pair scaling and reverse negation of the angle word
`timescale 1ns/10ps
`default_nettype none
module alh_angle_fmt #(
  parameter int W  = 12,
  parameter int SW = 4
) (
  alh_ang_if.fmtr port
);
  logic [W-1:0] shifted;

  always_comb begin
    // upper bits that overflow are dropped
    shifted = port.raw << port.shift;
    if (port.reverse) begin
      port.fmt = (~shifted) + {{(W-1){1'b0}}, 1'b1};
    end else begin
      port.fmt = shifted;
    end
  end
endmodule : alh_angle_fmt
`default_nettype wire

// ---- hw/alh_ctrl.sv ----
// controller that loads rotation angles into the vector rotator
`timescale 1ns/10ps
`default_nettype none
module alh_ctrl (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic [alh_pkg::ANG_W-1:0]    angle_in,
  input  wire logic [alh_pkg::SHW-1:0]      pole_shift_in,
  input  wire logic                         reverse_in,
  input  wire logic                         load_in,
  output logic                              ready_out,
  input  wire logic                         track_en_in,
  input  wire logic [alh_pkg::STEP_W-1:0]   step_period_in,
  output logic                              done_out,
  output logic                              error_out,
  output logic [alh_pkg::ANG_W-1:0]         angle_out,
  output logic                              strobe_out,
  input  wire logic                         busy_in
);
  import alh_pkg::*;

  alh_state_t         state_q;
  alh_state_t         state_d;
  logic [CNT_W-1:0]   cnt_q;
  logic               cnt_clr;
  logic [CNT_W-1:0]   fall_cnt_q;
  logic [ANG_W-1:0]   angle_q;
  logic               strobe_q;
  logic               done_q;
  logic               err_q;
  logic               busy_m_q;
  logic               busy_a_q;
  logic               busy_b_q;
  logic               busy_s_q;
  logic [STEP_W-1:0]  step_cnt_q;
  logic               step_pend_q;
  logic [ANG_W-1:0]   track_angle_q;
  logic               tick_w;
  logic               start_w;
  logic               done_w;
  logic               err_w;

  alh_ang_if #(.W(ANG_W), .SW(SHW)) ang ();

  assign ang.raw     = track_en_in ? track_angle_q : angle_in;
  assign ang.shift   = pole_shift_in;
  assign ang.reverse = reverse_in;

  alh_angle_fmt #(.W(ANG_W), .SW(SHW)) u_fmt (
    .port (ang.fmtr)
  );

  // busy pin: three stages, level accepted when the last two agree
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_m_q <= 1'b0;
      busy_a_q <= 1'b0;
      busy_b_q <= 1'b0;
      busy_s_q <= 1'b0;
    end else begin
      busy_m_q <= busy_in;
      busy_a_q <= busy_m_q;
      busy_b_q <= busy_a_q;
      if (busy_a_q == busy_b_q) begin
        busy_s_q <= busy_b_q;
      end
    end
  end

  // harmonic tracking: one angle step per programmed period
  assign tick_w = track_en_in && ({1'b0, step_cnt_q} + 25'h0000001 >= {1'b0, step_period_in});

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_cnt_q    <= '0;
      track_angle_q <= ANGLE_RST;
    end else if (!track_en_in) begin
      step_cnt_q    <= '0;
    end else if (tick_w) begin
      step_cnt_q    <= '0;
      track_angle_q <= track_angle_q + ANGLE_INC;
    end else begin
      step_cnt_q    <= step_cnt_q + 24'h000001;
    end
  end

  assign ready_out = (state_q == ST_IDLE) && !track_en_in;
  assign start_w   = (state_q == ST_IDLE) && (track_en_in ? step_pend_q : load_in);

  // a step that arrives while the previous one is taken stays pending
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      step_pend_q <= 1'b0;
    end else if (tick_w) begin
      step_pend_q <= 1'b1;
    end else if (start_w || !track_en_in) begin
      step_pend_q <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_clr = 1'b0;
    done_w  = 1'b0;
    err_w   = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        cnt_clr = 1'b1;
        if (start_w) begin
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_q >= SETUP_CYC - 10'h001 && fall_cnt_q >= GAP_CYC) begin
          state_d = ST_HIGH;
          cnt_clr = 1'b1;
        end
      end
      ST_HIGH: begin
        if (cnt_q == STB_HI_CYC - 10'h001) begin
          state_d = ST_WAIT;
          cnt_clr = 1'b1;
        end
      end
      ST_WAIT: begin
        if (busy_s_q) begin
          state_d = ST_BUSY;
          cnt_clr = 1'b1;
        end else if (cnt_q == RISE_TMO_CYC - 10'h001) begin
          state_d = ST_GAP;
          cnt_clr = 1'b1;
          err_w   = 1'b1;
        end
      end
      ST_BUSY: begin
        if (!busy_s_q) begin
          state_d = ST_GAP;
          cnt_clr = 1'b1;
          done_w  = 1'b1;
        end else if (cnt_q == BUSY_TMO_CYC - 10'h001) begin
          state_d = ST_GAP;
          cnt_clr = 1'b1;
          err_w   = 1'b1;
        end
      end
      ST_GAP: begin
        if (cnt_q == BUSY_GAP_CYC - 10'h001) begin
          state_d = ST_IDLE;
          cnt_clr = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_clr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_clr ? '0 : cnt_q + 10'h001;
    end
  end

  // angle word only changes when idle, so it is steady through busy
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      angle_q <= ANGLE_RST;
    end else if (start_w) begin
      angle_q <= ang.fmt;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_q   <= 1'b0;
      fall_cnt_q <= GAP_CYC;
    end else begin
      strobe_q <= (state_d == ST_HIGH);
      if (strobe_q && state_d != ST_HIGH) begin
        fall_cnt_q <= '0;
      end else if (fall_cnt_q < GAP_CYC) begin
        fall_cnt_q <= fall_cnt_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= done_w;
      err_q  <= err_w;
    end
  end

  assign angle_out  = angle_q;
  assign strobe_out = strobe_q;
  assign done_out   = done_q;
  assign error_out  = err_q;

  // checking helpers
  logic [CNT_W-1:0]  hi_len_q;
  logic [CNT_W-1:0]  lo_len_q;
  logic [ANG_W-1:0]  exp_shift;

  assign exp_shift = ang.raw << pole_shift_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_len_q <= '0;
      lo_len_q <= 10'h3ff;
    end else begin
      hi_len_q <= strobe_q ? hi_len_q + 10'h001 : '0;
      if (strobe_q) begin
        lo_len_q <= '0;
      end else if (lo_len_q != 10'h3ff) begin
        lo_len_q <= lo_len_q + 10'h001;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_strobe_width: assert property ($fell(strobe_q) |-> hi_len_q >= STB_HI_CYC)
    else $error("strobe high pulse too short");
  a_strobe_rate: assert property ($rose(strobe_q) |-> lo_len_q >= GAP_CYC)
    else $error("strobe rise too soon after previous fall");
  a_angle_steady: assert property (strobe_q && $past(strobe_q) |-> $stable(angle_out))
    else $error("angle word changed during strobe pulse");
  a_reverse_neg: assert property (start_w && reverse_in |=> angle_q + $past(exp_shift) == 12'h000)
    else $error("reverse load did not present negated angle");
  a_pole_shift: assert property (start_w && !reverse_in |=> angle_q == $past(exp_shift))
    else $error("angle not shifted for pole pairs");
  a_track_step: assert property (tick_w |=> track_angle_q == 12'($past(track_angle_q) + ANGLE_INC))
    else $error("tracking angle did not advance by one");
  // a period of 0 or 1 ticks every cycle, so a second tick right away is legal then
  a_step_restart: assert property (tick_w |=> step_cnt_q == '0
      ##1 (!track_en_in || !tick_w || step_period_in < 24'h000002))
    else $error("step period counter did not restart");
  a_busy_hold: assert property (busy_s_q && state_q == ST_BUSY |-> !strobe_q && $stable(angle_out))
    else $error("angle or strobe moved while busy");

  c_load_done: cover property (load_in && ready_out ##[1:600] done_q);
  c_reverse: cover property (start_w && reverse_in ##[1:600] done_q);
  c_timeout: cover property (err_q);
  c_track: cover property (tick_w ##[1:600] $rose(strobe_q));
endmodule : alh_ctrl
`default_nettype wire

// ---- hw/alh_pkg.sv ----
// constants and types shared by the angle-load handshake controller
package alh_pkg;
  localparam int ANG_W  = 12;
  localparam int SHW    = 4;
  localparam int STEP_W = 24;
  localparam int CNT_W  = 10;

  localparam int CLK_NS       = 10;
  localparam int SETUP_NS     = 25;
  localparam int STB_HI_NS    = 100;
  localparam int GAP_NS       = 2730;
  localparam int BUSY_GAP_NS  = 100;
  localparam int RISE_TMO_NS  = 1000;
  localparam int BUSY_TMO_NS  = 3000;

  // least times round up, timeouts round down
  localparam logic [CNT_W-1:0] SETUP_CYC    = CNT_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] STB_HI_CYC   = CNT_W'((STB_HI_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GAP_CYC      = CNT_W'((GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] BUSY_GAP_CYC = CNT_W'((BUSY_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RISE_TMO_CYC = CNT_W'(RISE_TMO_NS / CLK_NS);
  localparam logic [CNT_W-1:0] BUSY_TMO_CYC = CNT_W'(BUSY_TMO_NS / CLK_NS);

  localparam logic [ANG_W-1:0] ANGLE_RST = 12'h000;
  localparam logic [ANG_W-1:0] ANGLE_INC = 12'h001;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_HIGH  = 3'h3,
    ST_WAIT  = 3'h2,
    ST_BUSY  = 3'h6,
    ST_GAP   = 3'h7
  } alh_state_t;
endpackage : alh_pkg

// ---- testbench/alh_dev_model.sv ----
// behavioural model of the rotation device's angle-load pins
`timescale 1ns/10ps
`default_nettype none
module alh_dev_model
  import alh_pkg::*;
(
  input  wire logic             strobe_in,
  input  wire logic [ANG_W-1:0] angle_in,
  input  wire logic             answer_in,
  output logic                  busy_out,
  output logic [ANG_W-1:0]      loaded_out,
  output logic                  viol_out
);
  realtime          rise_t  = 0.0;
  realtime          fall_t  = -1.0e6;
  realtime          bfall_t = -1.0e6;
  logic             busy_q  = 1'b0;
  logic [ANG_W-1:0] load_q  = '0;
  logic             v_fall  = 1'b0;
  logic             v_rise  = 1'b0;
  logic             v_ang   = 1'b0;

  // each flag has one writer; the output merges them
  assign busy_out   = busy_q;
  assign loaded_out = load_q;
  assign viol_out   = v_fall | v_rise | v_ang;

  // a silent device never answers, so the controller must time out
  always @(negedge strobe_in) begin
    if ($realtime - rise_t < 100.0) v_fall = 1'b1;
    fall_t = $realtime;
    if (answer_in) begin
      load_q = angle_in;
      #30 busy_q = 1'b1;
      #2000 busy_q = 1'b0;
      bfall_t = $realtime;
    end
  end

  always @(posedge strobe_in) begin
    if ($realtime - fall_t < 2730.0 || $realtime - bfall_t < 100.0 || busy_q) v_rise = 1'b1;
    rise_t = $realtime;
  end

  always @(angle_in) begin
    if (busy_q) v_ang = 1'b1;
  end
endmodule : alh_dev_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the angle-load controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import alh_pkg::*;
  logic              clk_in = 1'b0, rst_in = 1'b1, load_in = 1'b0, reverse_in = 1'b0;
  logic              track_en_in = 1'b0, answer = 1'b1;
  logic [ANG_W-1:0]  angle_in = '0;
  logic [SHW-1:0]    pole_shift_in = '0;
  logic [STEP_W-1:0] step_period_in = 24'h000258;
  logic              ready_out, done_out, error_out, strobe_out, busy_in, viol;
  logic [ANG_W-1:0]  angle_out, loaded;
  logic [ANG_W-1:0]  exp_q[$];
  int                errors = 0, cmp_count = 0;

  alh_ctrl dut_u (.clk_in(clk_in), .rst_in(rst_in), .angle_in(angle_in), .pole_shift_in(pole_shift_in),
    .reverse_in(reverse_in), .load_in(load_in), .ready_out(ready_out), .track_en_in(track_en_in),
    .step_period_in(step_period_in), .done_out(done_out), .error_out(error_out), .angle_out(angle_out),
    .strobe_out(strobe_out), .busy_in(busy_in));
  alh_dev_model dev_u (.strobe_in(strobe_out), .angle_in(angle_out), .answer_in(answer),
    .busy_out(busy_in), .loaded_out(loaded), .viol_out(viol));

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic cmp_angle(input logic [ANG_W-1:0] got, input logic [ANG_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_angle

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_flag

  // waits on the falling edge so registered pulses are settled
  task automatic wait_end();
    int n;
    n = 0;
    while (done_out !== 1'b1 && error_out !== 1'b1) begin
      @(negedge clk_in);
      n++;
      if (n > 4000) begin
        errors++;
        report_and_stop();
      end
    end
  endtask : wait_end

  task automatic do_load(input logic [ANG_W-1:0] a, input logic [SHW-1:0] sh, input logic rv, input logic ok);
    int n;
    logic [ANG_W-1:0] e;
    n = 0;
    e = ANG_W'(int'(a) << sh);
    if (rv) e = ANG_W'(4096 - int'(e));
    exp_q.push_back(e);
    @(posedge clk_in);
    while (ready_out !== 1'b1) begin
      @(posedge clk_in);
      n++;
      if (n > 4000) begin
        errors++;
        report_and_stop();
      end
    end
    angle_in      <= a;
    pole_shift_in <= sh;
    reverse_in    <= rv;
    load_in       <= 1'b1;
    @(posedge clk_in);
    load_in <= 1'b0;
    wait_end();
    cmp_flag(done_out, ok);
    cmp_flag(error_out, !ok);
    e = exp_q.pop_front();
    if (ok) cmp_angle(loaded, e);
  endtask : do_load

  initial begin
    void'($urandom(97));
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    cmp_flag(strobe_out, 1'b0);
    cmp_angle(angle_out, 12'h000);
    do_load(12'hfff, 4'h0, 1'b0, 1'b1);
    do_load(12'h001, 4'h0, 1'b1, 1'b1);
    do_load(12'h0ab, 4'hb, 1'b0, 1'b1);
    for (int i = 0; i < 12; i++) begin
      do_load(ANG_W'($urandom), SHW'($urandom), 1'($urandom), 1'b1);
    end
    answer = 1'b0;
    do_load(12'h123, 4'h1, 1'b0, 1'b0);
    answer = 1'b1;
    do_load(12'h456, 4'h0, 1'b0, 1'b1);
    @(posedge clk_in);
    track_en_in <= 1'b1;
    @(negedge clk_in);
    cmp_flag(ready_out, 1'b0);
    wait_end();
    cmp_flag(done_out, 1'b1);
    cmp_angle(loaded, ANGLE_RST + ANGLE_INC);
    @(negedge clk_in);
    wait_end();
    cmp_flag(done_out, 1'b1);
    cmp_angle(loaded, ANGLE_RST + ANGLE_INC + ANGLE_INC);
    // reset in mid-run, after busy has fallen, returns every output to its idle value
    @(posedge clk_in);
    track_en_in <= 1'b0;
    rst_in      <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    cmp_flag(ready_out, 1'b1);
    cmp_flag(strobe_out, 1'b0);
    cmp_angle(angle_out, ANGLE_RST);
    cmp_flag(viol, 1'b0);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
